// ==== logic/sar_ctrl_pkg.sv ====
// package: constants and types of the converter control block
// assumes: one 125 MHz ref_clk samples every pin of the host side
`default_nettype none

package sar_ctrl_pkg;

  // result format
  localparam int RESULT_BITS = 12;
  localparam int CNT_W       = 5;

  typedef logic [RESULT_BITS-1:0] result_t;
  typedef logic [CNT_W-1:0]       cycle_cnt_t;

  // serial clock numbering: cycle n begins at the n-th falling edge
  localparam cycle_cnt_t CYC_DRIVE_LOW  = 5'h01;
  localparam cycle_cnt_t CYC_LAST_BIT   = 5'h0D;
  localparam cycle_cnt_t CYC_TAIL_OFF   = 5'h0E;
  localparam cycle_cnt_t CYC_FRAME_END  = 5'h10;
  localparam cycle_cnt_t CYC_LSBF_FIRST = 5'h0E;
  localparam cycle_cnt_t CYC_LSBF_LAST  = 5'h18;
  localparam cycle_cnt_t CYC_LSBF_OFF   = 5'h19;
  localparam cycle_cnt_t LSBF_REPEAT    = 5'h0B;

  localparam result_t RESULT_RESET = 12'h000;
  localparam result_t TRIAL_MSB    = 12'h800;

  // host timing, in printed units, and their cycle counts
  localparam int REF_CLK_PERIOD_NS = 8;
  localparam int ACQ_NS            = 350;
  localparam int SCLK_MIN_NS       = 125;
  localparam int SCLK_MAX_NS       = 5000;
  localparam int DROOP_US          = 5;
  localparam int ACQ_CYCLES        =
    (ACQ_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int SCLK_MIN_CYCLES   =
    (SCLK_MIN_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int SCLK_MAX_CYCLES   = SCLK_MAX_NS / REF_CLK_PERIOD_NS;
  localparam int DROOP_CYCLES      = (DROOP_US * 1000) / REF_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    S_SAMPLE,
    S_CONVERT,
    S_TAIL,
    S_LSBF
  } convert_strobe_state_t;

endpackage

`default_nettype wire

// ==== logic/result_if.sv ====
// interface: one result word with valid/ready between internal modules
// assumes: the source holds data and valid until ready is seen
`default_nettype none

interface result_if;
  sar_ctrl_pkg::result_t data;
  logic                  valid;
  logic                  ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// ==== logic/pin_sync.sv ====
// module: three-stage synchroniser with filtered level and edge pulses
// assumes: pin_async is asynchronous to clk; reset lasts >= 4 clocks
`default_nettype none

module pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_async,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic level_reg;
  logic rise_reg;
  logic fall_reg;

  // ff1 feeds ff2 only; stages run through reset so that an
  // idle-high pin gives no false edge once reset ends
  always_ff @(posedge clk) begin
    ff1_reg <= pin_async;
    ff2_reg <= ff1_reg;
    ff3_reg <= ff2_reg;
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= ff3_reg;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end else if (ff2_reg == ff3_reg && ff3_reg != level_reg) begin
      level_reg <= ff3_reg;
      rise_reg  <= ff3_reg;
      fall_reg  <= ~ff3_reg;
    end else begin
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end
  end

  assign level = level_reg;
  assign rise  = rise_reg;
  assign fall  = fall_reg;
endmodule

`default_nettype wire

// ==== logic/result_buffer.sv ====
// module: two-entry result buffer, valid/ready on both sides
// assumes: single clock; in_port.ready low when both entries are taken
`default_nettype none

module result_buffer (
  input  wire logic clk,
  input  wire logic rst,
  result_if.snk     in_port,
  result_if.src     out_port
);
  import sar_ctrl_pkg::*;

  result_t    mem [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign in_port.ready  = (count_reg != 2'h2);
  assign out_port.valid = (count_reg != 2'h0);
  assign out_port.data  = mem[rd_ptr_reg];
  assign push = in_port.valid && in_port.ready;
  assign pop  = out_port.valid && out_port.ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      mem[0] <= RESULT_RESET;
      mem[1] <= RESULT_RESET;
    end else if (push) begin
      mem[wr_ptr_reg] <= in_port.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ==== logic/sar_adc_serial_conversion_control.sv ====
// module: control and serial readout of a 12-bit SAR converter
// assumes: strobe, serial clock and comparator are asynchronous pins;
// ref_clk is at least eight times faster than the serial clock
`default_nettype none

// Overview of operation
// - strobe falling puts sample/hold into hold
// - strobe low at cycle 13 powers down
// - power-down lasts until strobe rises
// - first conversion after power-down is valid
// - full conversion and readout takes 16 clocks
// - strobe high then low in 13 selects LSB-first
// - LSB-first resends result over next 11 clocks
// - LSB-first powers down, strobe high resumes
// - strobe high then low before 13 short-cycles
// - strobe falling floats the data line at once
// - result is 12-bit straight unsigned binary
// - conversion start drives data line low
// - clock may stop while sampling or after conversion
module sar_adc_serial_conversion_control (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              convert_strobe,
  input  wire logic              serial_clk,
  input  wire logic              comparator_high,
  input  wire logic              result_ready,
  output logic                   hold_mode,
  output logic                   powered_down,
  output sar_ctrl_pkg::result_t  dac_trial_code,
  output logic                   serial_data,
  output logic                   serial_data_oe,
  output sar_ctrl_pkg::result_t  result_data,
  output logic                   result_valid
);
  import sar_ctrl_pkg::*;

  logic        strobe_lvl;
  logic        strobe_rise;
  logic        strobe_fall;
  logic        sclk_fall;
  logic        comp_lvl;
  convert_strobe_state_t state_reg;
  cycle_cnt_t  cnt_reg;
  cycle_cnt_t  cnt_next;
  result_t     code_reg;
  result_t     result_reg;
  result_t     pending_data_reg;
  logic        pending_reg;
  logic        went_high_reg;
  logic        pd_reg;
  logic        hold_reg;
  logic        data_reg;
  logic        oe_reg;
  logic        convert_strobe_start;
  logic        short_cycle;
  logic        lsbf_select;
  logic        last_bit_edge;
  logic        pd_at_13;
  result_t     final_word;

  result_if to_buf ();
  result_if from_buf ();

  // bit index sent in normal readout at a given serial cycle
  function automatic logic [3:0] msb_index(input cycle_cnt_t cyc);
    logic [4:0] idx;
    idx = CYC_LAST_BIT - cyc;
    return idx[3:0];
  endfunction

  // bit index resent in LSB-first readout at a given serial cycle
  function automatic logic [3:0] lsbf_index(input cycle_cnt_t cyc);
    logic [4:0] idx;
    idx = cyc - CYC_LAST_BIT;
    return idx[3:0];
  endfunction

  pin_sync u_strobe_sync (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .pin_async (convert_strobe),
    .level     (strobe_lvl),
    .rise      (strobe_rise),
    .fall      (strobe_fall)
  );

  // serial clock is only sampled; it may stop between frames
  pin_sync u_sclk_sync (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .pin_async (serial_clk),
    .level     (),
    .rise      (),
    .fall      (sclk_fall)
  );

  pin_sync u_comp_sync (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .pin_async (comparator_high),
    .level     (comp_lvl),
    .rise      (),
    .fall      ()
  );

  assign cnt_next      = cnt_reg + 5'h01;
  assign short_cycle   = strobe_fall && (state_reg == S_CONVERT);
  assign lsbf_select   = strobe_fall && (state_reg == S_TAIL);
  // any other falling strobe opens a fresh conversion
  assign convert_strobe_start    = strobe_fall && !lsbf_select;
  assign last_bit_edge = (state_reg == S_CONVERT) && sclk_fall &&
                         !strobe_fall && (cnt_next == CYC_LAST_BIT);
  assign pd_at_13      = last_bit_edge && !went_high_reg && !strobe_lvl;
  assign final_word    = {code_reg[RESULT_BITS-1:1], comp_lvl};

  // sequencing on serial clock edges
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= S_SAMPLE;
      cnt_reg   <= 5'h00;
    end else if (convert_strobe_start) begin
      // short cycle drops the partial word and restarts
      state_reg <= S_CONVERT;
      cnt_reg   <= 5'h00;
    end else if (lsbf_select) begin
      state_reg <= S_LSBF;
    end else if (sclk_fall) begin
      unique case (state_reg)
        S_SAMPLE: begin
          // edges while sampling do nothing
          cnt_reg <= cnt_reg;
        end
        S_CONVERT: begin
          cnt_reg <= cnt_next;
          if (cnt_next == CYC_LAST_BIT) begin
            state_reg <= S_TAIL;
          end
        end
        S_TAIL: begin
          cnt_reg <= cnt_next;
          if (cnt_next == CYC_FRAME_END) begin
            state_reg <= S_SAMPLE;
          end
        end
        S_LSBF: begin
          cnt_reg <= cnt_next;
          if (cnt_next == CYC_LSBF_OFF) begin
            state_reg <= S_SAMPLE;
          end
        end
      endcase
    end
  end

  // strobe seen high during the conversion blocks power-down at cycle 13
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      went_high_reg <= 1'b0;
    end else if (convert_strobe_start) begin
      went_high_reg <= 1'b0;
    end else if (strobe_rise && state_reg != S_SAMPLE) begin
      went_high_reg <= 1'b1;
    end
  end

  // hold from strobe fall until the last bit is decided or strobe rises
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hold_reg <= 1'b0;
    end else if (strobe_fall) begin
      // every fall holds, LSB-first entry as well
      hold_reg <= 1'b1;
    end else if (strobe_rise || last_bit_edge) begin
      hold_reg <= 1'b0;
    end
  end

  // power-down; entry wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pd_reg <= 1'b0;
    end else if (pd_at_13) begin
      pd_reg <= 1'b1;
    end else if (lsbf_select) begin
      pd_reg <= 1'b1;
    end else if (strobe_rise) begin
      pd_reg <= 1'b0;
    end
  end

  // successive approximation; power-down keeps no state in the way
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      code_reg <= RESULT_RESET;
    end else if (convert_strobe_start) begin
      code_reg <= RESULT_RESET;
    end else if (state_reg == S_CONVERT && sclk_fall) begin
      if (cnt_next == CYC_DRIVE_LOW) begin
        code_reg <= TRIAL_MSB;
      end else begin
        for (int b = 0; b < RESULT_BITS; b++) begin
          if (b == int'(msb_index(cnt_next))) begin
            code_reg[b] <= comp_lvl;
          end
        end
        // next trial bit in its own loop: no index below zero
        for (int b = 1; b < RESULT_BITS; b++) begin
          if (b == int'(msb_index(cnt_next))) begin
            code_reg[b-1] <= 1'b1;
          end
        end
      end
    end
  end

  // finished word kept for the LSB-first resend
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      result_reg <= RESULT_RESET;
    end else if (last_bit_edge) begin
      result_reg <= final_word;
    end
  end

  // pending word waits here while the buffer is full
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pending_reg      <= 1'b0;
      pending_data_reg <= RESULT_RESET;
    end else if (last_bit_edge) begin
      pending_reg      <= 1'b1;
      pending_data_reg <= final_word;
    end else if (to_buf.ready) begin
      pending_reg      <= 1'b0;
    end
  end

  // serial data line and its enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end else if (strobe_fall) begin
      // floats on every fall, even into LSB-first
      oe_reg   <= 1'b0;
    end else if (sclk_fall) begin
      unique case (state_reg)
        S_SAMPLE: begin
          oe_reg <= 1'b0;
        end
        S_CONVERT: begin
          oe_reg <= 1'b1;
          if (cnt_next == CYC_DRIVE_LOW) begin
            data_reg <= 1'b0;
          end else begin
            data_reg <= comp_lvl;
          end
        end
        S_TAIL: begin
          if (cnt_next == CYC_TAIL_OFF) begin
            oe_reg <= 1'b0;
          end
        end
        S_LSBF: begin
          if (cnt_next >= CYC_LSBF_FIRST && cnt_next <= CYC_LSBF_LAST)
          begin
            oe_reg   <= 1'b1;
            data_reg <= result_reg[lsbf_index(cnt_next)];
          end else begin
            oe_reg   <= 1'b0;
          end
        end
      endcase
    end
  end

  assign to_buf.valid = pending_reg;
  assign to_buf.data  = pending_data_reg;

  // buffer lets the on-chip reader stall for a word without loss
  result_buffer u_result_buffer (
    .clk      (ref_clk),
    .rst      (sys_rst),
    .in_port  (to_buf),
    .out_port (from_buf)
  );

  assign from_buf.ready = result_ready;
  assign result_valid   = from_buf.valid;
  assign result_data    = from_buf.data;

  assign hold_mode      = hold_reg;
  assign powered_down   = pd_reg;
  assign dac_trial_code = code_reg;
  assign serial_data    = data_reg;
  assign serial_data_oe = oe_reg;
endmodule

`default_nettype wire

// ==== dv/sar_ctrl_asserts.sv ====
// checker: port timing of the converter control block
// assumes: bound to the top module, all pins sampled by ref_clk
`default_nettype none

module sar_ctrl_asserts (
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  input wire logic                  convert_strobe,
  input wire logic                  serial_clk,
  input wire logic                  comparator_high,
  input wire logic                  result_ready,
  input wire logic                  hold_mode,
  input wire logic                  powered_down,
  input wire sar_ctrl_pkg::result_t dac_trial_code,
  input wire logic                  serial_data,
  input wire logic                  serial_data_oe,
  input wire sar_ctrl_pkg::result_t result_data,
  input wire logic                  result_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import sar_ctrl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // windows allow three sync flops plus two registers
  AST_HOLD_ON_FALL: assert property (
    $fell(convert_strobe) |-> ##[3:6] hold_mode)
    else $error("hold not entered after strobe fall");
  AST_FLOAT_ON_FALL: assert property (
    $fell(convert_strobe) |-> ##[3:6] !serial_data_oe)
    else $error("data line not released after strobe fall");
  AST_PD_ENTRY: assert property (
    $rose(powered_down) |-> !$past(convert_strobe, 3))
    else $error("power-down entered with strobe high");
  AST_PD_CLEAR: assert property (
    $fell(powered_down) |-> $past(convert_strobe, 3))
    else $error("power-down left without strobe high");
  AST_PD_EXIT: assert property (
    $rose(convert_strobe) |-> ##[3:6] !powered_down)
    else $error("power-down kept after strobe rise");
  AST_START_LOW: assert property (
    $rose(serial_data_oe) && hold_mode && !powered_down |-> !serial_data)
    else $error("conversion start not driven low");
  AST_LSB_AT_HOLD_END: assert property (
    $fell(hold_mode) && !$fell(powered_down) |-> serial_data_oe)
    else $error("last bit not driven as hold ends");
  AST_RESULT_STABLE: assert property (
    result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("waiting result word changed");
  cover property ($rose(powered_down));
  cover property (powered_down && serial_data_oe);
  cover property (result_valid && result_ready);
endmodule

bind sar_adc_serial_conversion_control sar_ctrl_asserts chk (
  .ref_clk, .sys_rst, .convert_strobe, .serial_clk, .comparator_high,
  .result_ready, .hold_mode, .powered_down, .dac_trial_code,
  .serial_data, .serial_data_oe, .result_data, .result_valid);

`default_nettype wire

// ==== dv/host_port_model.sv ====
// model: host serial port driving strobe and a gated serial clock
// assumes: data pin level already resolved with its pull-up
`default_nettype none

module host_port_model (
  output logic      convert_strobe,
  output logic      serial_clk,
  input  wire logic data_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cap;

  // clock idles high, still between frames
  initial begin
    convert_strobe = 1'b1;
    serial_clk     = 1'b1;
    cap            = '0;
  end

  task automatic strobe_high();
    convert_strobe = 1'b1;
  endtask

  task automatic acquire();
    convert_strobe = 1'b1;
    #400; // strobe high beyond acquisition time
    convert_strobe = 1'b0;
    #100; // clock starts well inside droop limit
  endtask

  // bit taken on rise; strobe moves only after that
  task automatic clocks(input int n, input real hp, input logic sv);
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'b0;
      #hp;
      cap = {cap[30:0], data_pin};
      serial_clk = 1'b1;
      if (i == 0) begin
        convert_strobe = sv;
      end
      #hp;
    end
  endtask
endmodule

`default_nettype wire

// ==== dv/tb_sar_adc_serial_conversion_control.sv ====
// testbench: host scenarios for the converter control block
// assumes: ideal comparator on the trial code, pull-up on data
`default_nettype none

`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end

module tb_sar_adc_serial_conversion_control;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_ctrl_pkg::*;
  logic      ref_clk;
  logic      sys_rst         = 1'b1;
  logic      comparator_high = 1'b0;
  logic      result_ready    = 1'b0;
  logic      hold_mode;
  logic      powered_down;
  logic      serial_data;
  logic      serial_data_oe;
  logic      result_valid;
  result_t   dac_trial_code;
  result_t   result_data;
  result_t   vin             = 12'h000;
  wire logic convert_strobe;
  wire logic serial_clk;
  wire logic data_pin;
  int        n_errors        = 0;
  int        check_count     = 0;

  // released line floats up
  assign data_pin = serial_data_oe ? serial_data : 1'b1;

  sar_adc_serial_conversion_control dut (
    .ref_clk, .sys_rst, .convert_strobe, .serial_clk, .comparator_high,
    .result_ready, .hold_mode, .powered_down, .dac_trial_code,
    .serial_data, .serial_data_oe, .result_data, .result_valid);

  host_port_model host (.convert_strobe, .serial_clk, .data_pin);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk) comparator_high <= (vin >= dac_trial_code);

  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic frame(input result_t v, input real hp);
    vin = v;
    host.acquire();
    host.clocks(16, hp, 1'b0);
    `CHK(host.cap[15:0], {1'b0, v, 3'b111})
    `CHK(dac_trial_code, v)
    `CHK(powered_down, 1'b1)
  endtask

  task automatic pop(input result_t v);
    int i;
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (result_valid !== 1'b1 && i < 100);
    `CHK(result_valid, 1'b1)
    `CHK(result_data, v)
    result_ready = 1'b1;
    @(negedge ref_clk);
    result_ready = 1'b0;
  endtask

  task automatic sc_power_down();
    frame(12'hA5C, 62.5);
    #1000;
    `CHK(powered_down, 1'b1)
    host.strobe_high();
    #100;
    `CHK(powered_down, 1'b0)
    pop(12'hA5C);
  endtask

  // first pass follows power-down; second follows a full frame
  task automatic sc_back_to_back();
    for (int k = 0; k < 2; k++) begin
      vin = k ? 12'h001 : 12'hFFE;
      host.acquire();
      host.clocks(16, 62.5, 1'b1);
      `CHK(host.cap[15:0], {1'b0, vin, 3'b111})
      `CHK(powered_down, 1'b0)
      pop(vin);
    end
  endtask

  task automatic sc_lsb_first();
    logic [24:0] e;
    vin = 12'h3B6;
    e = {1'b0, vin, 11'h000, 1'b1};
    for (int i = 1; i < 12; i++) e[12 - i] = vin[i];
    host.acquire();
    host.clocks(12, 62.5, 1'b1);
    host.clocks(13, 62.5, 1'b0);
    `CHK(host.cap[24:0], e)
    `CHK(powered_down, 1'b1)
    host.strobe_high();
    #100;
    `CHK(powered_down, 1'b0)
    pop(vin);
  endtask

  // aborted conversion must leave no word behind
  task automatic sc_short_cycle();
    vin = 12'h7FF;
    host.acquire();
    host.clocks(1, 62.5, 1'b1);
    host.clocks(1, 62.5, 1'b0);
    #100;
    `CHK(serial_data_oe, 1'b0)
    `CHK(hold_mode, 1'b1)
    `CHK(dac_trial_code, RESULT_RESET)
    vin = 12'h400;
    host.clocks(16, 62.5, 1'b0);
    `CHK(host.cap[15:0], {1'b0, vin, 3'b111})
    host.strobe_high();
    pop(vin);
  endtask

  // reader stalls over three frames: two buffered, one pending
  task automatic sc_buffer();
    frame(12'h111, 62.5);
    frame(12'h822, 62.5);
    frame(12'hC33, 62.5);
    pop(12'h111);
    pop(12'h822);
    pop(12'hC33);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    sc_power_down();
    sc_back_to_back();
    sc_lsb_first();
    sc_short_cycle();
    sc_buffer();
    summarize();
  end

  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule

`default_nettype wire
